// ---- shared/flash_seq_defines.vh ----
// Constants for the flash status flag sequencer
// Notes on behaviour
// RQ1: During write or erase, timeout flag reads 0 within limit, 1 beyond it.
// RQ2: Timeout flag: write done gives cell bit 5, erase done 1, wait/suspend 0.
// RQ3: Abnormal write or erase reads timeout flag as 1.
// RQ4: Programming 1 over 0 stalls, times out, and cell stays 0.
// RQ5: CPU treats timeout with ready low as failure and issues reset.
// RQ6: After sector erase command, erase-timer flag 0 during wait, then 1.
// RQ7: Erase-timer flag: 0 while writing, 1 when erasing, 0/1 on suspend/resume; the sequencer reads 1 for the suspended erased sector.
// RQ8: Abnormal write reads erase-timer 0; abnormal erase reads it 1.
// RQ9: While erasing, only the suspend command is taken.
// RQ10: CPU checks erase-timer reads 0 before adding another sector.
// RQ11: Suspended: erased sector reads erase-timer 1, others read stored bit 3.
// RQ12: CPU writes one command sequence back to back.
// RQ13: Read/reset state after reset and after normal command end; idle state.
// RQ14: Read/reset accepted as one write or four-write sequence, same effect.
// RQ15: Idle reads give array data; reset command recovers failed algorithm.
// RQ16: Programming starts when the fourth write cycle completes.
// RQ17: One byte per write command, any address order.
// RQ18: All commands ignored while programming.
// RQ19: CPU polls the address it last programmed.
// RQ20: Poll flag changes and toggle stops together with timeout rise.
// RQ21: Status bits: poll 7, toggle 6, timeout 5, erase-timer 3.
// RQ22: Programming reads give inverted bit 7 of written byte.
// RQ23: Toggle flag alternates on each read while algorithm runs.
// RQ24: Per-operation microsecond counter drives timeout and erase-timer flags.
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH

`define CLK_PERIOD_NS   50
`define NS_PER_US       1000
`define CYC_PER_US      (`NS_PER_US / `CLK_PERIOD_NS)
`define ERASE_WAIT_US   50
`define PROG_US         16
`define PROG_LIMIT_US   100
`define ERASE_US        200
`define ERASE_LIMIT_US  2000

`define UNLOCK_ADDR1    12'h555
`define UNLOCK_ADDR2    12'h2aa
`define CODE_UNLOCK1    8'haa
`define CODE_UNLOCK2    8'h55
`define CODE_RESET      8'hf0
`define CODE_PROG       8'ha0
`define CODE_ERASE      8'h80
`define CODE_SECTOR     8'h30
`define CODE_SUSPEND    8'hb0
`define CODE_RESUME     8'h30

`define POLL_BIT        7
`define TOGGLE_BIT      6
`define TIMEOUT_BIT     5
`define ETIMER_BIT      3

`define REG_FSR_IDX     12'h000
`define REG_CTRL_IDX    12'h001
`define FSR_READY_BIT   0
`define FSR_FAIL_BIT    1
`define FSR_SUSP_BIT    2
`define FSR_EWAIT_BIT   3
`define CTRL_CMD_EN_BIT 0
`define CTRL_RESET      1'b0

`endif

// ---- hdl/us_tick_gen.v ----
// Microsecond enable pulse divider
`timescale 1ns/1ns
`default_nettype none
module us_tick_gen #(
	parameter DIV = 20
) (
	input  wire core_clk_i,
	input  wire rstn_i,
	output wire tick_o
);
	reg [7:0] cnt_ff;
	reg       tick_ff;
	wire      wrap = (cnt_ff == DIV[7:0] - 8'h01);

	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_ff  <= 8'h00;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= wrap ? 8'h00 : cnt_ff + 8'h01;
			tick_ff <= wrap;
		end
	end

	assign tick_o = tick_ff;
endmodule
`default_nettype wire

// ---- hdl/flash_byte_array.v ----
// Flash cell array: registered read, program clears bits, erase sets
`timescale 1ns/1ns
`default_nettype none
module flash_byte_array #(
	parameter AW = 12
) (
	input  wire          core_clk_i,
	input  wire          wr_en_i,
	input  wire          wr_and_i,
	input  wire [AW-1:0] wr_addr_i,
	input  wire [7:0]    wr_data_i,
	input  wire          rd_en_i,
	input  wire [AW-1:0] rd_addr_i,
	output wire [7:0]    rd_data_o
);
	reg [7:0] mem [0:(1<<AW)-1];
	reg [7:0] rd_data_ff;

	// Programming can only clear bits
	always @(posedge core_clk_i) begin
		if (wr_en_i)
			mem[wr_addr_i] <= wr_and_i ? (mem[wr_addr_i] & wr_data_i)
				: wr_data_i; // RQ4
		if (rd_en_i)
			rd_data_ff <= mem[rd_addr_i];
	end

	assign rd_data_o = rd_data_ff;
endmodule
`default_nettype wire

// ---- hdl/flash_status_flag_sequencer.v ----
// Flash command sequencer with status flags behind an Avalon-MM slave
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_defines.vh"
module flash_status_flag_sequencer #(
	parameter        AW             = 12,
	parameter        SECT_W         = 2,
	parameter [15:0] PROG_US        = `PROG_US,
	parameter [15:0] PROG_LIMIT_US  = `PROG_LIMIT_US,
	parameter [15:0] ERASE_US       = `ERASE_US,
	parameter [15:0] ERASE_LIMIT_US = `ERASE_LIMIT_US
) (
	input  wire        core_clk_i,
	input  wire        rstn_i,
	input  wire [AW:0] avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output wire [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o
);
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_PROG  = 3'h1;
	localparam [2:0] ST_EWAIT = 3'h2;
	localparam [2:0] ST_ERASE = 3'h3;
	localparam [2:0] ST_SWEEP = 3'h4;
	localparam [2:0] ST_SUSP  = 3'h5;
	localparam [2:0] ST_FAIL  = 3'h6;
	localparam [1:0] BS_IDLE = 2'h0;
	localparam [1:0] BS_EXEC = 2'h1;
	localparam [1:0] BS_DONE = 2'h2;
	localparam        NSECT     = 1 << SECT_W;
	localparam [15:0] EWAIT_US  = `ERASE_WAIT_US;
	localparam [15:0] SAT_US    = 16'hffff;
	localparam [AW-1:0] LAST_AD = {AW{1'b1}};
	reg [2:0]       state_ff;
	reg [2:0]       susp_ret_ff;
	reg [1:0]       bus_ff;
	reg             waitreq_ff;
	reg [31:0]      readdata_ff;
	reg [AW:0]      lat_addr_ff;
	reg             lat_wr_ff;
	reg             lat_be0_ff;
	reg [7:0]       lat_data_ff;
	reg [2:0]       cyc_ff;
	reg [NSECT-1:0] sect_mask_ff;
	reg [AW-1:0]    prog_addr_ff;
	reg [7:0]       prog_data_ff;
	reg [7:0]       old_ff;
	reg [15:0]      us_cnt_ff;
	reg             toggle_ff;
	reg             fail_erase_ff;
	reg             cmd_en_ff;
	reg [AW-1:0]    sweep_ff;
	wire            tick;
	wire [7:0]      mem_rdata;
	function [SECT_W-1:0] sector_of;
		input [AW-1:0] a;
		sector_of = a[AW-1:AW-SECT_W];
	endfunction
	function [7:0] status_byte;
		input poll;
		input tog;
		input tmo;
		input etm;
		begin
			status_byte = 8'h00;
			status_byte[`POLL_BIT]    = poll; // RQ21
			status_byte[`TOGGLE_BIT]  = tog;
			status_byte[`TIMEOUT_BIT] = tmo;
			status_byte[`ETIMER_BIT]  = etm;
		end
	endfunction
	function [NSECT-1:0] sect_bit;
		input [SECT_W-1:0] s;
		sect_bit = {{(NSECT-1){1'b0}}, 1'b1} << s;
	endfunction
	wire req      = (avs_read_i | avs_write_i) & (bus_ff == BS_IDLE);
	wire exec     = (bus_ff == BS_EXEC);
	wire lat_reg  = lat_addr_ff[AW];
	wire [AW-1:0] lat_a = lat_addr_ff[AW-1:0];
	wire arr_rd   = exec & ~lat_wr_ff & ~lat_reg;
	wire arr_cmd  = exec & lat_wr_ff & ~lat_reg & lat_be0_ff & cmd_en_ff;
	wire busy     = (state_ff == ST_PROG) | (state_ff == ST_EWAIT) |
	                (state_ff == ST_ERASE) | (state_ff == ST_SWEEP);
	// Programming a 1 over a 0 never completes
	wire prog_bad  = |(~old_ff & prog_data_ff); // RQ4
	wire prog_ok   = (state_ff == ST_PROG) & ~prog_bad &
	                 (us_cnt_ff >= PROG_US);
	wire prog_fail = (state_ff == ST_PROG) &
	                 (us_cnt_ff >= PROG_LIMIT_US); // RQ1
	wire erase_fail = ((state_ff == ST_ERASE) | (state_ff == ST_SWEEP)) &
	                  (us_cnt_ff >= ERASE_LIMIT_US); // RQ1
	wire sweep_we  = (state_ff == ST_SWEEP) &
	                 sect_mask_ff[sector_of(sweep_ff)];
	wire mem_we    = prog_ok | prog_fail | sweep_we;
	us_tick_gen #(
		.DIV (`CYC_PER_US)
	) u_tick (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.tick_o     (tick)
	);
	flash_byte_array #(
		.AW (AW)
	) u_array (
		.core_clk_i (core_clk_i),
		.wr_en_i    (mem_we),
		.wr_and_i   (~sweep_we),
		.wr_addr_i  (sweep_we ? sweep_ff : prog_addr_ff),
		.wr_data_i  (sweep_we ? 8'hff : prog_data_ff),
		.rd_en_i    (req),
		.rd_addr_i  (avs_address_i[AW-1:0]),
		.rd_data_o  (mem_rdata)
	);
	// Read data for the current access
	reg [31:0] nxt_readdata;
	always @* begin
		nxt_readdata = 32'h00000000;
		if (lat_reg) begin
			if (lat_a == `REG_FSR_IDX) begin
				nxt_readdata[`FSR_READY_BIT] = (state_ff == ST_IDLE);
				nxt_readdata[`FSR_FAIL_BIT]  = (state_ff == ST_FAIL);
				nxt_readdata[`FSR_SUSP_BIT]  = (state_ff == ST_SUSP);
				nxt_readdata[`FSR_EWAIT_BIT] = (state_ff == ST_EWAIT);
			end else if (lat_a == `REG_CTRL_IDX) begin
				nxt_readdata[`CTRL_CMD_EN_BIT] = cmd_en_ff;
			end
		end else begin
			case (state_ff)
			ST_IDLE:
				nxt_readdata[7:0] = mem_rdata; // RQ15
			ST_PROG:
				nxt_readdata[7:0] = status_byte(~prog_data_ff[7],
					toggle_ff, 1'b0, 1'b0); // RQ22
			ST_EWAIT:
				nxt_readdata[7:0] = status_byte(1'b0, toggle_ff,
					1'b0, 1'b0); // RQ6
			ST_ERASE, ST_SWEEP:
				nxt_readdata[7:0] = status_byte(1'b0, toggle_ff,
					1'b0, 1'b1); // RQ7
			ST_SUSP: begin
				if (sect_mask_ff[sector_of(lat_a)])
					nxt_readdata[7:0] = status_byte(1'b1, 1'b1,
						1'b0, 1'b1); // RQ11
				else
					nxt_readdata[7:0] = mem_rdata; // RQ11
			end
			ST_FAIL: begin
				// Poll flag flips and toggle freezes on timeout
				if (fail_erase_ff)
					nxt_readdata[7:0] = status_byte(1'b1, toggle_ff,
						1'b1, 1'b1); // RQ8
				else
					nxt_readdata[7:0] = status_byte(prog_data_ff[7],
						toggle_ff, 1'b1, 1'b0); // RQ20
			end
			default:
				nxt_readdata[7:0] = mem_rdata;
			endcase
		end
	end
	// Bus handshake: take, execute, answer
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_ff      <= BS_IDLE;
			waitreq_ff  <= 1'b1;
			readdata_ff <= 32'h00000000;
			lat_addr_ff <= {(AW+1){1'b0}};
			lat_wr_ff   <= 1'b0;
			lat_be0_ff  <= 1'b0;
			lat_data_ff <= 8'h00;
		end else begin
			case (bus_ff)
			BS_IDLE: begin
				if (req) begin
					bus_ff      <= BS_EXEC;
					lat_addr_ff <= avs_address_i;
					lat_wr_ff   <= avs_write_i;
					lat_be0_ff  <= avs_byteenable_i[0];
					lat_data_ff <= avs_writedata_i[7:0];
				end
			end
			BS_EXEC: begin
				bus_ff     <= BS_DONE;
				waitreq_ff <= 1'b0;
				if (!lat_wr_ff)
					readdata_ff <= nxt_readdata;
			end
			default: begin
				bus_ff     <= BS_IDLE;
				waitreq_ff <= 1'b1;
			end
			endcase
		end
	end
	// Control register
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			cmd_en_ff <= `CTRL_RESET;
		else if (exec & lat_wr_ff & lat_reg & lat_be0_ff &
		         (lat_a == `REG_CTRL_IDX))
			cmd_en_ff <= lat_data_ff[`CTRL_CMD_EN_BIT];
	end
	// Toggle flag flips per array read while the algorithm runs
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			toggle_ff <= 1'b0;
		else if (arr_rd & busy)
			toggle_ff <= ~toggle_ff; // RQ23
	end
	// Sequencer state machine
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_ff      <= ST_IDLE; // RQ13
			susp_ret_ff   <= ST_ERASE;
			cyc_ff        <= 3'h0;
			sect_mask_ff  <= {NSECT{1'b0}};
			prog_addr_ff  <= {AW{1'b0}};
			prog_data_ff  <= 8'h00;
			old_ff        <= 8'h00;
			us_cnt_ff     <= 16'h0000;
			fail_erase_ff <= 1'b0;
			sweep_ff      <= {AW{1'b0}};
		end else begin
			if (busy & tick & (us_cnt_ff != SAT_US))
				us_cnt_ff <= us_cnt_ff + 16'h0001; // RQ24
			if (state_ff == ST_SWEEP)
				sweep_ff <= sweep_ff + {{(AW-1){1'b0}}, 1'b1};
			if (prog_fail) begin
				state_ff      <= ST_FAIL; // RQ3
				fail_erase_ff <= 1'b0;
			end else if (prog_ok) begin
				state_ff <= ST_IDLE; // RQ13
			end
			if (erase_fail) begin
				state_ff      <= ST_FAIL; // RQ3
				fail_erase_ff <= 1'b1;
			end else if ((state_ff == ST_ERASE) &
			             (us_cnt_ff >= ERASE_US)) begin
				state_ff <= ST_SWEEP;
				sweep_ff <= {AW{1'b0}};
			end else if ((state_ff == ST_SWEEP) & (sweep_ff == LAST_AD)) begin
				state_ff     <= ST_IDLE; // RQ13
				sect_mask_ff <= {NSECT{1'b0}};
			end
			if ((state_ff == ST_EWAIT) & (us_cnt_ff >= EWAIT_US)) begin
				state_ff  <= ST_ERASE; // RQ6
				us_cnt_ff <= 16'h0000;
			end
			if (arr_cmd) begin
				case (state_ff)
				ST_IDLE: begin
					if (lat_data_ff == `CODE_RESET) begin
						cyc_ff <= 3'h0; // RQ14
					end else begin
						case (cyc_ff)
						3'h0, 3'h4:
							cyc_ff <= (lat_a == `UNLOCK_ADDR1 &&
								lat_data_ff == `CODE_UNLOCK1) ?
								cyc_ff + 3'h1 : 3'h0;
						3'h1, 3'h5:
							cyc_ff <= (lat_a == `UNLOCK_ADDR2 &&
								lat_data_ff == `CODE_UNLOCK2) ?
								cyc_ff + 3'h1 : 3'h0;
						3'h2: begin
							if (lat_a == `UNLOCK_ADDR1 &&
							    lat_data_ff == `CODE_PROG)
								cyc_ff <= 3'h3;
							else if (lat_a == `UNLOCK_ADDR1 &&
							         lat_data_ff == `CODE_ERASE)
								cyc_ff <= 3'h4;
							else
								cyc_ff <= 3'h0;
						end
						3'h3: begin
							state_ff     <= ST_PROG; // RQ16
							prog_addr_ff <= lat_a; // RQ17
							prog_data_ff <= lat_data_ff;
							old_ff       <= mem_rdata;
							us_cnt_ff    <= 16'h0000;
							cyc_ff       <= 3'h0;
						end
						3'h6: begin
							cyc_ff <= 3'h0;
							if (lat_data_ff == `CODE_SECTOR) begin
								state_ff     <= ST_EWAIT;
								sect_mask_ff <= sect_bit(sector_of(lat_a));
								us_cnt_ff    <= 16'h0000;
							end
						end
						default:
							cyc_ff <= 3'h0;
						endcase
					end
				end
				ST_EWAIT: begin
					if (lat_data_ff == `CODE_SUSPEND) begin
						state_ff    <= ST_SUSP;
						susp_ret_ff <= ST_ERASE;
						us_cnt_ff   <= 16'h0000;
					end else if (lat_data_ff == `CODE_SECTOR) begin
						sect_mask_ff <= sect_mask_ff |
							sect_bit(sector_of(lat_a));
						state_ff     <= ST_EWAIT;
						us_cnt_ff    <= 16'h0000;
					end
				end
				ST_ERASE, ST_SWEEP: begin
					if (lat_data_ff == `CODE_SUSPEND) begin // RQ9
						state_ff    <= ST_SUSP;
						susp_ret_ff <= state_ff;
					end
				end
				ST_SUSP: begin
					if (lat_data_ff == `CODE_RESUME)
						state_ff <= susp_ret_ff;
				end
				ST_FAIL: begin
					if (lat_data_ff == `CODE_RESET) begin
						state_ff     <= ST_IDLE; // RQ15
						cyc_ff       <= 3'h0;
						sect_mask_ff <= {NSECT{1'b0}};
					end
				end
				default: begin
					cyc_ff <= 3'h0; // RQ18
				end
				endcase
			end
		end
	end

	assign avs_readdata_o    = readdata_ff;
	assign avs_waitrequest_o = waitreq_ff;
endmodule
`default_nettype wire

// ---- tb/flash_seq_monitor.sv ----
// Bus-port assertions for the flash status flag sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_seq_monitor #(
	parameter AW = 12
) (
	input wire logic          core_clk_i,
	input wire logic          rstn_i,
	input wire logic [AW:0]   avs_address_i,
	input wire logic          avs_read_i,
	input wire logic          avs_write_i,
	input wire logic [31:0]   avs_writedata_i,
	input wire logic [3:0]    avs_byteenable_i,
	input wire logic [31:0]   avs_readdata_o,
	input wire logic          avs_waitrequest_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	wire ans_rd = !avs_waitrequest_o && avs_read_i;
	wire ans_wr = !avs_waitrequest_o && avs_write_i;
	wire arr = !avs_address_i[AW];
	wire [AW-1:0] idx = avs_address_i[AW-1:0];
	logic          ctrl_ff;
	logic          wr_seen_ff;
	logic [AW:0]   last_a_ff;
	logic [7:0]    last_d_ff;
	// Shadow of control bit and last array read with no write since
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_ff <= 1'b0;
			wr_seen_ff <= 1'b1;
			last_a_ff <= '0;
			last_d_ff <= '0;
		end else begin
			if (ans_wr && !arr && idx == AW'(1) && avs_byteenable_i[0])
				ctrl_ff <= avs_writedata_i[0];
			if (ans_wr)
				wr_seen_ff <= 1'b1;
			else if (ans_rd && arr)
				wr_seen_ff <= 1'b0;
			if (ans_rd && arr)
				last_a_ff <= avs_address_i;
			if (ans_rd && arr)
				last_d_ff <= avs_readdata_o[7:0];
		end
	end
	a_wait_two: assert property ($rose(avs_read_i || avs_write_i) |->
		avs_waitrequest_o [*2] ##1 !avs_waitrequest_o)
		else $error("answer not two edges after request");
	a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	a_rd_stable: assert property ($changed(avs_readdata_o) |-> ans_rd)
		else $error("readdata changed outside a read answer");
	a_upper_zero: assert property (ans_rd |-> avs_readdata_o[31:8] == 24'h0)
		else $error("readdata upper bits not zero");
	a_unmapped_zero: assert property (ans_rd && !arr && idx > AW'(1)
		|-> avs_readdata_o == 32'h0)
		else $error("unmapped register read not zero");
	a_ctrl_readback: assert property (ans_rd && !arr && idx == AW'(1)
		|-> avs_readdata_o[0] == ctrl_ff)
		else $error("control bit readback wrong");
	a_fsr_exclusive: assert property (ans_rd && !arr && idx == AW'(0)
		|-> !(avs_readdata_o[0] && |avs_readdata_o[3:1]))
		else $error("ready together with busy status");
	a_toggle_frozen: assert property (ans_rd && arr && !wr_seen_ff
		&& avs_address_i == last_a_ff && last_d_ff[5] && avs_readdata_o[5]
		|-> avs_readdata_o[6] == last_d_ff[6])
		else $error("toggle flag moved after timeout");
endmodule
bind flash_status_flag_sequencer flash_seq_monitor #(.AW(AW)) u_mon (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o));
`default_nettype wire

// ---- tb/cpu_bus_master.sv ----
// CPU model issuing flash command sequences over the bus
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_defines.vh"
module cpu_bus_master (
	input  wire logic        core_clk_i,
	input  wire logic [31:0] avs_readdata_i,
	input  wire logic        avs_waitrequest_i,
	output var logic [12:0]  avs_address_o,
	output var logic         avs_read_o,
	output var logic         avs_write_o,
	output var logic [31:0]  avs_writedata_o,
	output var logic [3:0]   avs_byteenable_o
);
	initial begin
		avs_address_o = 13'h0;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = 32'h0;
		avs_byteenable_o = 4'h1;
	end
	task automatic acc(input logic w, input logic [12:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk_i);
		avs_address_o <= a;
		avs_read_o <= !w;
		avs_write_o <= w;
		avs_writedata_o <= {24'h0, d};
		do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
		q = avs_readdata_i[7:0];
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
		// Released lines show no stale value
		avs_address_o <= ~a;
		avs_writedata_o <= ~{24'h0, d};
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, {1'b0, a}, d, q);
	endtask
	task automatic unlock();
		wr(`UNLOCK_ADDR1, `CODE_UNLOCK1);
		wr(`UNLOCK_ADDR2, `CODE_UNLOCK2);
	endtask
	task automatic prog(input logic [11:0] a, input logic [7:0] d);
		unlock();
		wr(`UNLOCK_ADDR1, `CODE_PROG);
		wr(a, d);
	endtask
	task automatic sect_erase(input logic [11:0] a);
		unlock();
		wr(`UNLOCK_ADDR1, `CODE_ERASE);
		unlock();
		wr(a, `CODE_SECTOR);
	endtask
	task automatic reset_cmd(input logic four);
		if (four) begin
			unlock();
			wr(`UNLOCK_ADDR1, `CODE_RESET);
		end
		wr(12'h000, `CODE_RESET);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_flash_status_flag_sequencer.sv ----
// Self-checking bench for the flash status flag sequencer
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_defines.vh"
module tb_flash_status_flag_sequencer;
	localparam logic [12:0] FSR_A = 13'h1000;
	localparam logic [12:0] CTL_A = 13'h1001;
	logic        core_clk_i;
	logic        rstn_i;
	logic [12:0] addr;
	logic        rd_s;
	logic        wr_s;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0]  be;
	logic        wreq;
	logic [7:0]  q;
	logic [7:0]  q2;
	int          bad_count = 0;
	int          n_compared = 0;
	int          cyc = 0;
	// Rows: write, address, write data, expected read
	logic [29:0] rows [7] = '{
		{1'b0, FSR_A, 8'h00, 8'h01}, {1'b0, CTL_A, 8'h00, 8'h00},
		{1'b0, 13'h1005, 8'h00, 8'h00}, {1'b1, 13'h1005, 8'hff, 8'h00},
		{1'b0, 13'h1005, 8'h00, 8'h00}, {1'b1, CTL_A, 8'h01, 8'h00},
		{1'b0, CTL_A, 8'h00, 8'h01}};
	flash_status_flag_sequencer #(.PROG_US(16'd4), .PROG_LIMIT_US(16'd10),
		.ERASE_US(16'd2), .ERASE_LIMIT_US(16'd500)) dut (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(addr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq));
	cpu_bus_master cpu (
		.core_clk_i(core_clk_i), .avs_readdata_i(rdata),
		.avs_waitrequest_i(wreq), .avs_address_o(addr), .avs_read_o(rd_s),
		.avs_write_o(wr_s), .avs_writedata_o(wdata), .avs_byteenable_o(be));
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic poll(input logic [12:0] a, input logic [7:0] m,
		input logic [7:0] v);
		int n;
		n = 0;
		do begin
			cpu.acc(1'b0, a, 8'h00, q);
			n++;
		end while ((q & m) !== v && n < 3000);
		chk(q & m, v);
	endtask
	task automatic rd2(input logic [12:0] a);
		cpu.acc(1'b0, a, 8'h00, q);
		cpu.acc(1'b0, a, 8'h00, q2);
	endtask
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		rstn_i = 1'b0;
		repeat (6) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		foreach (rows[i]) begin
			cpu.acc(rows[i][29], rows[i][28:16], rows[i][15:8], q);
			if (!rows[i][29])
				chk(q, rows[i][7:0]);
		end
		cpu.acc(1'b0, FSR_A, 8'h00, q);
		chk(q & 8'h08, 8'h00);
		cpu.sect_erase(12'h000);
		cpu.acc(1'b0, 13'h0000, 8'h00, q);
		chk(q & 8'ha8, 8'h00);
		poll(13'h0000, 8'h08, 8'h08);
		rd2(13'h0000);
		chk(q & 8'ha0, 8'h00);
		chk((q ^ q2) & 8'h40, 8'h40);
		cpu.wr(12'h000, `CODE_RESET);
		cpu.acc(1'b0, FSR_A, 8'h00, q);
		chk(q & 8'h01, 8'h00);
		cpu.wr(12'h000, `CODE_SUSPEND);
		poll(FSR_A, 8'h04, 8'h04);
		cpu.acc(1'b0, 13'h0000, 8'h00, q);
		chk(q & 8'he8, 8'hc8);
		cpu.wr(12'h000, `CODE_RESUME);
		poll(FSR_A, 8'h01, 8'h01);
		cpu.acc(1'b0, 13'h0000, 8'h00, q);
		chk(q, 8'hff);
		cpu.prog(12'h012, 8'h5a);
		cpu.acc(1'b0, 13'h0012, 8'h00, q);
		chk(q & 8'ha8, 8'h80);
		// A second program during programming must be dropped
		cpu.prog(12'h013, 8'h00);
		poll(13'h0012, 8'hff, 8'h5a);
		cpu.acc(1'b0, 13'h0013, 8'h00, q);
		chk(q, 8'hff);
		for (int k = 0; k < 2; k++) begin
			cpu.prog(12'h012, 8'hff);
			poll(FSR_A, 8'h02, 8'h02);
			rd2(13'h0012);
			chk(q & 8'hb8, 8'ha0);
			chk((q ^ q2) & 8'h40, 8'h00);
			cpu.acc(1'b0, FSR_A, 8'h00, q);
			chk(q & 8'h01, 8'h00);
			cpu.reset_cmd(k[0]);
			cpu.acc(1'b0, FSR_A, 8'h00, q);
			chk(q, 8'h01);
			cpu.acc(1'b0, 13'h0012, 8'h00, q);
			chk(q, 8'h5a);
		end
		// Reset during programming: idle again, commands locked out
		cpu.prog(12'h013, 8'h00);
		rstn_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		cpu.acc(1'b0, FSR_A, 8'h00, q);
		chk(q, 8'h01);
		cpu.acc(1'b0, CTL_A, 8'h00, q);
		chk(q, 8'h00);
		cpu.prog(12'h014, 8'h00);
		cpu.acc(1'b0, 13'h0014, 8'h00, q);
		chk(q, 8'hff);
		print_verdict();
	end
endmodule
`default_nettype wire
